// ===== core/mct_params.svh
// timing and limit constants for the multi-capture trigger handshake
`ifndef MCT_PARAMS_SVH
`define MCT_PARAMS_SVH

`define MCT_CLK_NS 8
`define MCT_SEC_NS 1000000000
`define MCT_CYC_PER_S (`MCT_SEC_NS / `MCT_CLK_NS)
`define MCT_TIMEOUT_W 6
`define MCT_TIMEOUT_MAX_S 6'h3C
`define MCT_TASK_W 4

`endif

// ===== core/mct_pkg.sv
// types for the multi-capture trigger handshake
package mct_pkg;

	typedef enum logic [2:0] {
		MCT_IDLE = 3'h0,
		MCT_SETUP = 3'h1,
		MCT_ACQ = 3'h3,
		MCT_WAITM = 3'h2,
		MCT_ARMED = 3'h6,
		MCT_DRAIN = 3'h7,
		MCT_POST = 3'h5
	} mct_state_e;

endpackage : mct_pkg

// ===== core/mct_wait_timer.sv
// seconds timer that flags a missing capture trigger
`timescale 1ns/1ns
`include "mct_params.svh"

module mct_wait_timer #(
	parameter int CYC_PER_S = `MCT_CYC_PER_S
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic run,
	input wire logic [`MCT_TIMEOUT_W-1:0] limit_s,
	output logic expired_q
);
	localparam int PW = $clog2(CYC_PER_S);
	localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_S - 1);

	logic [PW-1:0] pre_q;
	logic [`MCT_TIMEOUT_W-1:0] sec_q;
	logic [`MCT_TIMEOUT_W-1:0] lim;
	logic tick;

	// settings above the top of the range are held at the top
	assign lim = (limit_s > `MCT_TIMEOUT_MAX_S) ? `MCT_TIMEOUT_MAX_S : limit_s;
	assign tick = (pre_q == PRE_LAST);

	always_ff @(posedge core_clk) begin
		if (!nrst || !run) begin
			pre_q <= '0;
			sec_q <= '0;
			expired_q <= 1'b0;
		end else begin
			expired_q <= 1'b0;
			pre_q <= tick ? '0 : pre_q + PW'(1);
			// a zero limit never expires; one pulse only, then the counter parks
			if (tick && lim != '0 && sec_q != lim) begin
				sec_q <= sec_q + `MCT_TIMEOUT_W'(1);
				expired_q <= (sec_q + `MCT_TIMEOUT_W'(1) == lim);
			end
		end
	end

	a_expire_needs_run: assert property (@(posedge core_clk) disable iff (!nrst)
		expired_q |-> $past(run) && lim != '0)
		else $error("timer expired without a running wait");

endmodule : mct_wait_timer

// ===== core/mct_trigger_seq.sv
// trigger, ready and busy sequencer for a multi-capture inspection
`timescale 1ns/1ns
`include "mct_params.svh"

module mct_trigger_seq #(
	parameter int CYC_PER_S = `MCT_CYC_PER_S,
	parameter int TW = `MCT_TASK_W
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic step_in,
	input wire logic cfg_shared_setup,
	input wire logic cfg_parallel,
	input wire logic [`MCT_TIMEOUT_W-1:0] cfg_timeout_s,
	input wire logic [TW-1:0] cfg_task_count,
	input wire logic cam_setup_done,
	input wire logic acq_done,
	input wire logic meas_done,
	input wire logic [TW-1:0] meas_done_id,
	input wire logic post_done,
	output logic ready_q,
	output logic busy_q,
	output logic cam_setup_start_q,
	output logic [TW-1:0] cam_cfg_idx_q,
	output logic acq_start_q,
	output logic meas_start_q,
	output logic [TW-1:0] meas_id_q,
	output logic post_start_q,
	output logic display_start_q,
	output logic seq_fail_q,
	output logic step_err_q
);
	import mct_pkg::*;

	mct_state_e state_q;
	logic step_m_q, step_s_q, step_p_q;
	logic step_rise;
	logic shared_q, par_q;
	logic [TW-1:0] ntask_q, task_q;
	logic [TW-1:0] acq_cnt_q, iss_q, done_q;
	logic last_task, can_issue, expired, start_seq;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// pin synchroniser; only the second flop and later are looked at
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			step_m_q <= 1'b0;
			step_s_q <= 1'b0;
			step_p_q <= 1'b0;
		end else begin
			step_m_q <= step_in;
			step_s_q <= step_m_q;
			step_p_q <= step_s_q;
		end
	end

	assign step_rise = step_s_q & ~step_p_q;
	assign last_task = (task_q == ntask_q - TW'(1));
	assign start_seq = (state_q == MCT_IDLE) && step_rise;

	// edges that arrive while ready is low are dropped and reported
	always_ff @(posedge core_clk) begin
		if (!nrst)
			step_err_q <= 1'b0;
		else
			step_err_q <= step_rise && !ready_q;
	end

	mct_wait_timer #(
		.CYC_PER_S(CYC_PER_S)
	) u_wait (
		.core_clk(core_clk),
		.nrst(nrst),
		.run(state_q == MCT_ARMED),
		.limit_s(cfg_timeout_s),
		.expired_q(expired)
	);

	// handshake sequencer
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_q <= MCT_IDLE;
			ready_q <= 1'b1;
			busy_q <= 1'b0;
			task_q <= '0;
			ntask_q <= TW'(1);
			shared_q <= 1'b1;
			par_q <= 1'b1;
			cam_setup_start_q <= 1'b0;
			cam_cfg_idx_q <= '0;
			acq_start_q <= 1'b0;
			post_start_q <= 1'b0;
			display_start_q <= 1'b0;
			seq_fail_q <= 1'b0;
		end else begin
			cam_setup_start_q <= 1'b0;
			acq_start_q <= 1'b0;
			post_start_q <= 1'b0;
			display_start_q <= 1'b0;
			case (state_q)
				MCT_IDLE: begin
					if (start_seq) begin
						// modes are frozen for the whole sequence
						ready_q <= 1'b0;
						busy_q <= 1'b1;
						task_q <= '0;
						ntask_q <= (cfg_task_count == '0) ? TW'(1) : cfg_task_count;
						shared_q <= cfg_shared_setup;
						par_q <= cfg_parallel;
						seq_fail_q <= 1'b0;
						cam_setup_start_q <= 1'b1;
						cam_cfg_idx_q <= '0;
						state_q <= MCT_SETUP;
					end
				end
				MCT_SETUP: begin
					if (cam_setup_done) begin
						acq_start_q <= 1'b1;
						state_q <= MCT_ACQ;
					end
				end
				MCT_ACQ: begin
					if (acq_done) begin
						if (last_task)
							state_q <= MCT_DRAIN;
						else if (shared_q || (par_q && task_q == '0)) begin
							ready_q <= 1'b1;
							state_q <= MCT_ARMED;
						end else
							state_q <= MCT_WAITM;
					end
				end
				MCT_WAITM: begin
					if (meas_done && meas_done_id == task_q) begin
						ready_q <= 1'b1;
						state_q <= MCT_ARMED;
					end
				end
				MCT_ARMED: begin
					if (step_rise) begin
						ready_q <= 1'b0;
						task_q <= task_q + TW'(1);
						if (shared_q) begin
							acq_start_q <= 1'b1;
							state_q <= MCT_ACQ;
						end else begin
							cam_setup_start_q <= 1'b1;
							cam_cfg_idx_q <= task_q + TW'(1);
							state_q <= MCT_SETUP;
						end
					end else if (expired) begin
						// no more captures; finish what was acquired and report NG
						ready_q <= 1'b0;
						seq_fail_q <= 1'b1;
						state_q <= MCT_DRAIN;
					end
				end
				MCT_DRAIN: begin
					if (done_q == acq_cnt_q && iss_q == acq_cnt_q) begin
						post_start_q <= 1'b1;
						state_q <= MCT_POST;
					end
				end
				MCT_POST: begin
					if (post_done) begin
						busy_q <= 1'b0;
						ready_q <= 1'b1;
						display_start_q <= 1'b1;
						state_q <= MCT_IDLE;
					end
				end
				default: begin
					ready_q <= 1'b1;
					busy_q <= 1'b0;
					state_q <= MCT_IDLE;
				end
			endcase
		end
	end

	// task measurements: overlapped when concurrent, one at a time otherwise
	assign can_issue = busy_q && (iss_q != acq_cnt_q) && (par_q || iss_q == done_q);

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			acq_cnt_q <= '0;
			done_q <= '0;
		end else if (start_seq) begin
			acq_cnt_q <= '0;
			done_q <= '0;
		end else begin
			if (state_q == MCT_ACQ && acq_done)
				acq_cnt_q <= acq_cnt_q + TW'(1);
			if (meas_done && busy_q)
				done_q <= done_q + TW'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			iss_q <= '0;
			meas_start_q <= 1'b0;
			meas_id_q <= '0;
		end else begin
			meas_start_q <= 1'b0;
			if (start_seq)
				iss_q <= '0;
			else if (can_issue) begin
				meas_start_q <= 1'b1;
				meas_id_q <= iss_q;
				iss_q <= iss_q + TW'(1);
			end
		end
	end

	a_step_rejected: assert property (step_rise && !ready_q |=> $stable(task_q) && step_err_q)
		else $error("trigger taken while ready was low");
	a_first_trigger: assert property (start_seq |=> !ready_q && busy_q && cam_setup_start_q)
		else $error("first trigger did not drop ready and raise busy");
	a_later_trigger: assert property (state_q == MCT_ARMED && step_rise |=> !ready_q && busy_q)
		else $error("later trigger did not drop ready");
	a_shared_ready: assert property (state_q == MCT_ACQ && acq_done && shared_q && !last_task |=> ready_q)
		else $error("shared setup ready not back after acquisition");
	a_shared_no_setup: assert property (cam_setup_start_q && shared_q |-> cam_cfg_idx_q == '0)
		else $error("camera reconfigured in shared setup");
	a_per_cap_setup: assert property (state_q == MCT_ARMED && step_rise && !shared_q
		|=> cam_setup_start_q && !acq_start_q && cam_cfg_idx_q == task_q)
		else $error("per-capture setup skipped");
	a_wait_meas_low: assert property (state_q == MCT_WAITM |-> !ready_q && busy_q)
		else $error("ready high before task measurement ended");
	a_seq_one_meas: assert property (!par_q && meas_start_q |-> iss_q == done_q + TW'(1))
		else $error("sequential measurement overlapped");
	a_post_after_all: assert property (post_start_q
		|-> done_q == acq_cnt_q && (seq_fail_q || acq_cnt_q == ntask_q))
		else $error("post measurement started early");
	a_busy_then_disp: assert property ($fell(busy_q) |-> display_start_q && $past(post_done))
		else $error("busy fell without display or post end");
	a_timeout_fail: assert property (state_q == MCT_ARMED && expired && !step_rise
		|=> seq_fail_q && state_q == MCT_DRAIN)
		else $error("timeout did not fail the sequence");

endmodule : mct_trigger_seq

// ===== test/mct_plc_model.sv
// line controller model that drives the capture trigger
`timescale 1ns/1ns

module mct_plc_model (
	input wire logic core_clk,
	input wire logic ready_q,
	input wire logic busy_q,
	output logic step_in
);
	initial step_in = 1'b0;

	// decisions on the falling edge so the registered answers have settled
	task automatic trig(input bit first);
		while (!(ready_q && (!first || !busy_q))) @(negedge core_clk);
		@(posedge core_clk) step_in <= 1'b1;
		@(negedge core_clk);
		while (ready_q || (first && !busy_q)) @(negedge core_clk);
		@(posedge core_clk) step_in <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : trig

	// deliberately ignores ready, used only to provoke a refusal
	task automatic bump();
		@(posedge core_clk) step_in <= 1'b1;
		repeat (4) @(posedge core_clk);
		step_in <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : bump
endmodule : mct_plc_model

// ===== test/testbench.sv
// self-checking bench for the trigger sequencer with engine responders
`timescale 1ns/1ns

module testbench;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic step_in, cfg_shared_setup = 1'b0, cfg_parallel = 1'b0;
	logic [5:0] cfg_timeout_s = 6'h00;
	logic [3:0] cfg_task_count = 4'h1, meas_done_id = 4'h0, cam_cfg_idx_q, meas_id_q;
	logic cam_setup_done = 1'b0, acq_done = 1'b0, meas_done = 1'b0, post_done = 1'b0;
	logic ready_q, busy_q, cam_setup_start_q, acq_start_q, meas_start_q;
	logic post_start_q, display_start_q, seq_fail_q, step_err_q;
	int error_cnt = 0, comparisons = 0, cyc = 0, seed = 76, slow = 0;
	int sd = 0, ad = 0, md = 0, pd = 0, af = 0, ntask = 1;
	int nsu, nacq, nms, nmd, nps, ndisp, nerr, nexp;
	logic [3:0] mq[$];

	always #4 core_clk = ~core_clk;

	mct_plc_model plc (.core_clk(core_clk), .ready_q(ready_q), .busy_q(busy_q), .step_in(step_in));

	mct_trigger_seq #(.CYC_PER_S(20)) dut (.core_clk(core_clk), .nrst(nrst), .step_in(step_in),
		.cfg_shared_setup(cfg_shared_setup), .cfg_parallel(cfg_parallel), .cfg_timeout_s(cfg_timeout_s),
		.cfg_task_count(cfg_task_count), .cam_setup_done(cam_setup_done), .acq_done(acq_done),
		.meas_done(meas_done), .meas_done_id(meas_done_id), .post_done(post_done), .ready_q(ready_q),
		.busy_q(busy_q), .cam_setup_start_q(cam_setup_start_q), .cam_cfg_idx_q(cam_cfg_idx_q),
		.acq_start_q(acq_start_q), .meas_start_q(meas_start_q), .meas_id_q(meas_id_q),
		.post_start_q(post_start_q), .display_start_q(display_start_q), .seq_fail_q(seq_fail_q),
		.step_err_q(step_err_q));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk

	function automatic int dly();
		return 2 + slow + ($random(seed) & 3);
	endfunction : dly

	// ready after the k-th acquisition: the configured task count decides the last one, not the triggers sent
	function automatic logic exp_ready(input int k);
		return k < ntask && (cfg_shared_setup || (cfg_parallel && k == 1));
	endfunction : exp_ready

	// engines answer after random delays; slow stretches them to hold ready low
	always @(negedge core_clk) begin
		if (sd > 0) sd--;
		if (ad > 0) ad--;
		if (pd > 0) pd--;
		if (cam_setup_start_q) begin
			chk(cam_cfg_idx_q, nsu);
			nsu++;
			sd = dly();
		end
		if (acq_start_q) ad = dly();
		if (post_start_q) begin
			chk(nmd, nms);
			nps++;
			pd = dly();
		end
		if (af) chk(ready_q, exp_ready(nacq));
		af = acq_done;
		if (acq_done) nacq++;
		if (meas_start_q) begin
			if (!cfg_parallel) chk(nms - nmd, 0);
			chk(meas_id_q, nms);
			// concurrent mode must not wait for older measurements
			if (cfg_parallel) chk(meas_id_q, nacq - 1);
			mq.push_back(meas_id_q);
			nms++;
		end
		if (meas_done) nmd++;
		if (md == 1) void'(mq.pop_front());
		if (md > 0) md--;
		else if (mq.size() > 0) md = dly();
		if (display_start_q) begin
			chk(busy_q, 0);
			ndisp++;
		end
		if (step_err_q) nerr++;
	end

	always @(posedge core_clk) begin
		cam_setup_done <= sd == 1;
		acq_done <= ad == 1;
		meas_done <= md == 1;
		meas_done_id <= mq.size() > 0 ? mq[0] : 4'h0;
		post_done <= pd == 1;
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic run(input bit sh, input bit pa, input int n, input bit rude, input bit to);
		@(posedge core_clk);
		cfg_shared_setup <= sh;
		cfg_parallel <= pa;
		cfg_task_count <= n[3:0];
		cfg_timeout_s <= to ? 6'h01 : 6'h00;
		slow = rude ? 8 : 0;
		nsu = 0;
		nacq = 0;
		nms = 0;
		nmd = 0;
		nps = 0;
		ndisp = 0;
		nerr = 0;
		ntask = n;
		nexp = to ? 1 : n;
		for (int k = 0; k < nexp; k++) begin
			plc.trig(k == 0);
			if (k == 0) chk(busy_q, 1);
			if (rude && k == 0) plc.bump();
		end
		while (busy_q) @(negedge core_clk);
		// let the responder block finish its bookkeeping of this falling edge first
		@(posedge core_clk);
		chk(nsu, sh ? 1 : nexp);
		chk(nacq, nexp);
		chk(nms, nexp);
		chk(nps + ndisp, 2);
		chk(nerr, rude);
		chk(seq_fail_q, to);
		$display("test done shared=%0d par=%0d n=%0d", sh, pa, n);
	endtask : run

	task automatic summarize();
		$display("compares %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	initial begin
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			run(i[0], i[1], 2 + ($random(seed) & 3), 0, 0);
		end
		run(1, 0, 1, 0, 0);
		run(0, 0, 3, 1, 0);
		run(1, 1, 3, 0, 1);
		summarize();
	end
endmodule : testbench
